// file: include/fncs_pkg.sv
// package of constants for the fieldbus node configuration selector
package fncs_pkg;
  // switch and address limits
  localparam logic [6:0] ADDR_MAX = 7'h3f;      // highest switch-selectable node address
  localparam logic [3:0] RATE_SW_MAX = 4'h2;    // highest switch-selectable rate code
  localparam logic [3:0] DIGIT_MAX = 4'h9;      // decimal rotary switch top position
  // bit rate codes
  localparam logic [1:0] RATE_125K = 2'h0;      // 125 kbit/s
  localparam logic [1:0] RATE_250K = 2'h1;      // 250 kbit/s
  localparam logic [1:0] RATE_500K = 2'h2;      // 500 kbit/s
  // terminal rate command values in kbit/s
  localparam logic [9:0] KBPS_125 = 10'h07d;    // value 125
  localparam logic [9:0] KBPS_250 = 10'h0fa;    // value 250
  localparam logic [9:0] KBPS_500 = 10'h1f4;    // value 500
  // network object identifiers
  localparam logic [7:0] OBJ_CLASS_LINK = 8'h03; // link object class
  localparam logic [7:0] OBJ_ATTR_ADDR = 8'h01;  // stored node address attribute
  localparam logic [7:0] OBJ_ATTR_RATE = 8'h02;  // stored rate code attribute
  localparam logic [7:0] OBJ_CLASS_NVM = 8'h25;  // parameter store class
  localparam logic [7:0] OBJ_ATTR_SAVE = 8'h65;  // save-to-memory attribute
  // register byte offsets
  localparam logic [7:0] OFS_CMD = 8'h00;       // command: write triggers action
  localparam logic [7:0] OFS_OBJ = 8'h04;       // network object write
  localparam logic [7:0] OFS_PEND = 8'h08;      // pending (unsaved) parameters, read
  localparam logic [7:0] OFS_SAVED = 8'h0c;     // saved parameters, read
  localparam logic [7:0] OFS_ACTIVE = 8'h10;    // active configuration, read
  localparam logic [7:0] OFS_SWITCH = 8'h14;    // switches latched at restart, read
  // command codes in cmd[31:28]
  localparam logic [3:0] CMD_ADDR = 4'h1;       // node_address_set_command
  localparam logic [3:0] CMD_RATE = 4'h2;       // bit_rate_set_command
  localparam logic [3:0] CMD_SAVE = 4'h3;       // save parameters
  localparam logic [3:0] CMD_COLD = 4'h4;       // cold_restart_command
  // reset values of stored parameters
  localparam logic [5:0] ADDR_RESET = 6'h3f;    // stored address after power-up
  localparam logic [1:0] RATE_RESET = 2'h0;     // stored rate after power-up
  localparam logic [1:0] RESP_OKAY = 2'h0;      // axi okay
  localparam logic [1:0] RESP_SLVERR = 2'h2;    // axi slave error
  localparam logic [1:0] RESP_DECERR = 2'h3;    // axi decode error
endpackage

// file: verilog/fncs_sync2.sv
// two-flop synchroniser for the switch inputs
`timescale 1ns/10ps
module fncs_sync2 #(
  parameter int WIDTH = 4
) (
  input wire logic aclk,               // system clock
  input wire logic aresetn,            // synchronous reset, active low
  input wire logic [WIDTH-1:0] d,      // asynchronous input
  output logic [WIDTH-1:0] q           // synchronised output
);
  logic [WIDTH-1:0] meta_reg; // first stage, read only by second

  // two stages, reset to zero
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      meta_reg <= '0;
      q <= '0;
    end
    else
    begin
      meta_reg <= d;
      q <= meta_reg;
    end
  end
endmodule

// file: verilog/fncs_top.sv
// fieldbus node address and bit rate selector with axi4-lite registers
//
// Design decisions made here: the AXI4-Lite slave port and the register offsets.
`timescale 1ns/10ps
module fncs_top
  import fncs_pkg::*;
(
  input wire logic aclk,                  // 10 mhz clock
  input wire logic aresetn,               // synchronous reset, active low
  input wire logic [3:0] address_tens_switch,  // tens digit rotary switch
  input wire logic [3:0] address_units_switch, // units digit rotary switch
  input wire logic [3:0] rate_switch,     // bit rate rotary switch
  input wire logic [7:0] s_axi_awaddr,    // write address
  input wire logic s_axi_awvalid,         // write address valid
  output logic s_axi_awready,             // write address ready
  input wire logic [31:0] s_axi_wdata,    // write data
  input wire logic [3:0] s_axi_wstrb,     // write strobes
  input wire logic s_axi_wvalid,          // write data valid
  output logic s_axi_wready,              // write data ready
  output logic [1:0] s_axi_bresp,         // write response
  output logic s_axi_bvalid,              // write response valid
  input wire logic s_axi_bready,          // write response ready
  input wire logic [7:0] s_axi_araddr,    // read address
  input wire logic s_axi_arvalid,         // read address valid
  output logic s_axi_arready,             // read address ready
  output logic [31:0] s_axi_rdata,        // read data
  output logic [1:0] s_axi_rresp,         // read response
  output logic s_axi_rvalid,              // read valid
  input wire logic s_axi_rready,          // read ready
  output logic [5:0] node_address,        // active node address
  output logic [1:0] bit_rate_code,       // active rate code
  output logic config_valid               // high once a restart has loaded config
);
  // ------------------------------------------------------------
  // switch synchronisers
  // ------------------------------------------------------------
  logic [3:0] tens_s; // synchronised tens digit
  logic [3:0] units_s; // synchronised units digit
  logic [3:0] rate_s; // synchronised rate switch

  fncs_sync2 #(.WIDTH(12)) u_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .d({address_tens_switch, address_units_switch, rate_switch}),
    .q({tens_s, units_s, rate_s})
  );

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  logic [5:0] pend_addr_reg; // written by command or object, not yet saved
  logic [1:0] pend_rate_reg; // pending rate code
  logic [5:0] saved_addr_reg; // non-volatile copy
  logic [1:0] saved_rate_reg; // non-volatile copy
  logic [3:0] lat_tens_reg; // tens digit latched at restart
  logic [3:0] lat_units_reg; // units digit latched at restart
  logic [3:0] lat_rate_reg; // rate switch latched at restart
  logic [5:0] act_addr_reg; // active address
  logic [1:0] act_rate_reg; // active rate
  logic act_addr_sw_reg; // address came from switches
  logic act_rate_sw_reg; // rate came from switches
  logic [1:0] load_cnt_reg; // restart sampling delay, lets synchronisers settle
  logic cfg_ok_reg; // configuration loaded

  // ------------------------------------------------------------
  // axi write channel
  // ------------------------------------------------------------
  logic aw_held_reg; // address taken, waiting for data
  logic w_held_reg; // data taken, waiting for address
  logic [7:0] awaddr_reg; // held write address
  logic [31:0] wdata_reg; // held write data
  logic bvalid_reg; // response pending
  logic [1:0] bresp_reg; // response code

  wire aw_fire = s_axi_awvalid && s_axi_awready; // address handshake
  wire w_fire = s_axi_wvalid && s_axi_wready; // data handshake
  wire wr_go = aw_held_reg && w_held_reg; // both halves present
  wire [31:0] wd = wdata_reg; // data being applied
  wire full_word = (s_axi_wstrb == 4'hf); // unused after capture; strobes ignored
  wire is_cmd = (awaddr_reg == OFS_CMD); // command register hit
  wire is_obj = (awaddr_reg == OFS_OBJ); // object register hit
  wire wr_mapped = is_cmd || is_obj; // writable offsets
  wire [3:0] cmd_code = wd[31:28]; // command code
  wire [9:0] cmd_val = wd[9:0]; // command argument
  wire [7:0] obj_class = wd[31:24]; // object class
  wire [7:0] obj_attr = wd[23:16]; // object attribute
  wire [7:0] obj_val = wd[7:0]; // object value
  // stored parameters may be written only when switches hand control to them
  wire addr_sw_over = !act_addr_sw_reg; // address switches hold a digit above 9 or a sum above 63
  wire rate_sw_over = !act_rate_sw_reg; // rate switch above 2
  // command decode
  wire c_addr = wr_go && is_cmd && cmd_code == CMD_ADDR && addr_sw_over
                && cmd_val <= {3'h0, ADDR_MAX};
  wire rate_125 = cmd_val == KBPS_125; // 125 requested
  wire rate_250 = cmd_val == KBPS_250; // 250 requested
  wire rate_500 = cmd_val == KBPS_500; // 500 requested
  wire c_rate = wr_go && is_cmd && cmd_code == CMD_RATE && rate_sw_over
                && (rate_125 || rate_250 || rate_500);
  wire c_save = wr_go && is_cmd && cmd_code == CMD_SAVE; // terminal save
  wire c_cold = wr_go && is_cmd && cmd_code == CMD_COLD; // cold restart
  // object decode
  wire o_addr = wr_go && is_obj && obj_class == OBJ_CLASS_LINK && obj_attr == OBJ_ATTR_ADDR
                && addr_sw_over && obj_val <= {1'b0, ADDR_MAX};
  wire o_rate = wr_go && is_obj && obj_class == OBJ_CLASS_LINK && obj_attr == OBJ_ATTR_RATE
                && rate_sw_over && obj_val <= {4'h0, RATE_SW_MAX};
  wire o_save = wr_go && is_obj && obj_class == OBJ_CLASS_NVM
                && obj_attr == OBJ_ATTR_SAVE;
  wire wr_ok = c_addr || c_rate || c_save || c_cold || o_addr || o_rate || o_save; // accepted
  wire [1:0] rate_from_cmd = rate_500 ? RATE_500K : (rate_250 ? RATE_250K : RATE_125K);
  wire [1:0] wr_resp = !wr_mapped ? RESP_DECERR : (wr_ok ? RESP_OKAY : RESP_SLVERR);

  assign s_axi_awready = !aw_held_reg && !bvalid_reg; // free slot for address
  assign s_axi_wready = !w_held_reg && !bvalid_reg; // free slot for data
  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;

  // capture address and data in either order, answer once both are held
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_held_reg <= 1'b0;
      w_held_reg <= 1'b0;
      awaddr_reg <= 8'h00;
      wdata_reg <= 32'h0000_0000;
      bvalid_reg <= 1'b0;
      bresp_reg <= RESP_OKAY;
    end
    else
    begin
      if (aw_fire)
      begin
        aw_held_reg <= 1'b1;
        awaddr_reg <= {s_axi_awaddr[7:2], 2'b00};
      end
      if (w_fire)
      begin
        w_held_reg <= 1'b1;
        wdata_reg <= s_axi_wdata;
      end
      if (wr_go)
      begin
        aw_held_reg <= 1'b0;
        w_held_reg <= 1'b0;
        bvalid_reg <= 1'b1;
        bresp_reg <= wr_resp;
      end
      else if (bvalid_reg && s_axi_bready)
        bvalid_reg <= 1'b0;
    end
  end

  // ------------------------------------------------------------
  // parameter store: pending, saved, active
  // ------------------------------------------------------------
  // saved values survive a cold restart; only aresetn (power-up) resets them, to ADDR_RESET and RATE_RESET
  wire do_save = c_save || o_save;
  wire restart = c_cold || !cfg_ok_reg && load_cnt_reg == 2'h3; // load trigger
  wire tens_ok = lat_tens_reg <= DIGIT_MAX; // valid decimal digit
  wire units_ok = lat_units_reg <= DIGIT_MAX; // valid decimal digit
  wire [6:0] sw_addr = 7'(lat_tens_reg) * 7'd10 + 7'(lat_units_reg);
  wire addr_from_sw = tens_ok && units_ok && sw_addr <= ADDR_MAX;
  wire rate_from_sw = lat_rate_reg <= RATE_SW_MAX;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      pend_addr_reg <= ADDR_RESET;
      pend_rate_reg <= RATE_RESET;
      saved_addr_reg <= ADDR_RESET;
      saved_rate_reg <= RATE_RESET;
    end
    else
    begin
      if (c_addr)
        pend_addr_reg <= cmd_val[5:0];
      else if (o_addr)
        pend_addr_reg <= obj_val[5:0];
      if (c_rate)
        pend_rate_reg <= rate_from_cmd;
      else if (o_rate)
        pend_rate_reg <= obj_val[1:0];
      if (do_save)
      begin
        saved_addr_reg <= pend_addr_reg;
        saved_rate_reg <= pend_rate_reg;
      end
    end
  end

  // restart sequence: latch switches, then pick the active source
  // the switch latch and the selection are one cycle apart, so the
  // selection uses the latch from the same restart
  logic sel_pend_reg; // selection due next cycle
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      load_cnt_reg <= 2'h0;
      cfg_ok_reg <= 1'b0;
      sel_pend_reg <= 1'b0;
      lat_tens_reg <= 4'h0;
      lat_units_reg <= 4'h0;
      lat_rate_reg <= 4'h0;
      act_addr_reg <= 6'h00;
      act_rate_reg <= RATE_125K;
      act_addr_sw_reg <= 1'b1;
      act_rate_sw_reg <= 1'b1;
    end
    else
    begin
      if (!cfg_ok_reg && load_cnt_reg != 2'h3)
        load_cnt_reg <= load_cnt_reg + 2'h1; // wait out synchroniser fill
      sel_pend_reg <= restart;
      if (restart)
      begin
        // switches are read here only, ignored while running
        lat_tens_reg <= tens_s;
        lat_units_reg <= units_s;
        lat_rate_reg <= rate_s;
        cfg_ok_reg <= 1'b0;
      end
      if (sel_pend_reg)
      begin
        act_addr_sw_reg <= addr_from_sw;
        act_rate_sw_reg <= rate_from_sw;
        act_addr_reg <= addr_from_sw ? sw_addr[5:0] : saved_addr_reg;
        act_rate_reg <= rate_from_sw ? lat_rate_reg[1:0] : saved_rate_reg;
        cfg_ok_reg <= 1'b1;
      end
    end
  end

  assign node_address = act_addr_reg;
  assign bit_rate_code = act_rate_reg;
  assign config_valid = cfg_ok_reg;

  // ------------------------------------------------------------
  // axi read channel
  // ------------------------------------------------------------
  logic rvalid_reg; // read data pending
  logic [31:0] rdata_reg; // read data
  logic [1:0] rresp_reg; // read response

  wire [7:0] ra = {s_axi_araddr[7:2], 2'b00}; // aligned read address
  wire r_pend = ra == OFS_PEND; // pending hit
  wire r_saved = ra == OFS_SAVED; // saved hit
  wire r_act = ra == OFS_ACTIVE; // active hit
  wire r_sw = ra == OFS_SWITCH; // switch hit
  wire r_zero = ra == OFS_CMD || ra == OFS_OBJ; // write-only, reads zero
  wire r_mapped = r_pend || r_saved || r_act || r_sw || r_zero; // known offset
  wire [31:0] rd_mux =
    r_pend ? {22'h0, pend_rate_reg, 2'h0, pend_addr_reg} :
    r_saved ? {22'h0, saved_rate_reg, 2'h0, saved_addr_reg} :
    r_act ? {19'h0, cfg_ok_reg, act_rate_sw_reg, act_addr_sw_reg, act_rate_reg,
             2'h0, act_addr_reg} :
    r_sw ? {20'h0, lat_rate_reg, lat_tens_reg, lat_units_reg} : 32'h0000_0000;

  assign s_axi_arready = !rvalid_reg; // one read at a time
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rdata = rdata_reg;
  assign s_axi_rresp = rresp_reg;

  // register read data one cycle after the address is taken
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rvalid_reg <= 1'b0;
      rdata_reg <= 32'h0000_0000;
      rresp_reg <= RESP_OKAY;
    end
    else if (s_axi_arvalid && !rvalid_reg)
    begin
      rvalid_reg <= 1'b1;
      rdata_reg <= rd_mux;
      rresp_reg <= r_mapped ? RESP_OKAY : RESP_DECERR;
    end
    else if (rvalid_reg && s_axi_rready)
      rvalid_reg <= 1'b0;
  end
endmodule

// file: bench/fncs_host_model.sv
// host and network tool model: axi4-lite master for the selector registers
`timescale 1ns/10ps
module fncs_host_model
  import fncs_pkg::*;
(
  input wire logic aclk, // system clock
  output logic [7:0] s_axi_awaddr, // write address
  output logic s_axi_awvalid, // write address valid
  input wire logic s_axi_awready, // write address ready
  output logic [31:0] s_axi_wdata, // write data
  output logic [3:0] s_axi_wstrb, // write strobes
  output logic s_axi_wvalid, // write data valid
  input wire logic s_axi_wready, // write data ready
  input wire logic [1:0] s_axi_bresp, // write response
  input wire logic s_axi_bvalid, // write response valid
  output logic s_axi_bready, // write response ready
  output logic [7:0] s_axi_araddr, // read address
  output logic s_axi_arvalid, // read address valid
  input wire logic s_axi_arready, // read address ready
  input wire logic [31:0] s_axi_rdata, // read data
  input wire logic [1:0] s_axi_rresp, // read response
  input wire logic s_axi_rvalid, // read valid
  output logic s_axi_rready // read ready
);
  // ----------------------------------------
  // bus idle at time zero
  // ----------------------------------------
  initial
  begin
    {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
    s_axi_wstrb = 4'hf; // full words only
  end
  // one write: address and data offered together, each dropped when taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] resp);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
    end
    while (s_axi_bvalid !== 1'b1);
    resp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  // one read: rready held until rvalid is sampled
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] resp);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
    end
    while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata;
    resp = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  // save then cold restart, always in that order, never one alone
  task automatic save_restart(output logic [1:0] r1, output logic [1:0] r2);
    wr(OFS_CMD, {CMD_SAVE, 28'h0}, r1);
    wr(OFS_CMD, {CMD_COLD, 28'h0}, r2);
  endtask
endmodule

// file: bench/fncs_top_asserts.sv
// concurrent checks on the node configuration selector ports
`timescale 1ns/10ps
module fncs_top_asserts
  import fncs_pkg::*;
(
  input wire logic aclk, // system clock
  input wire logic aresetn, // sync reset, active low
  input wire logic [3:0] address_tens_switch, // tens switch
  input wire logic [3:0] address_units_switch, // units switch
  input wire logic [3:0] rate_switch, // rate switch
  input wire logic s_axi_awready, // write address ready
  input wire logic s_axi_wready, // write data ready
  input wire logic s_axi_bvalid, // write response valid
  input wire logic s_axi_bready, // write response ready
  input wire logic s_axi_arready, // read address ready
  input wire logic [31:0] s_axi_rdata, // read data
  input wire logic [1:0] s_axi_rresp, // read response
  input wire logic s_axi_rvalid, // read valid
  input wire logic s_axi_rready, // read ready
  input wire logic [5:0] node_address, // active address
  input wire logic [1:0] bit_rate_code, // active rate
  input wire logic config_valid // config loaded
);
  logic [7:0] sw_sum; // decimal switch address
  assign sw_sum = 8'(address_tens_switch) * 8'h0a + 8'(address_units_switch);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  AST_CFG_LOAD: assert property ($rose(aresetn) |-> ##[1:10] config_valid)
    else $error("config not loaded after reset");
  // outside a restart window the active pair must not move
  AST_CFG_HOLD: assert property (config_valid && $past(config_valid) && !s_axi_bvalid &&
    !$past(s_axi_bvalid) |-> $stable(node_address) && $stable(bit_rate_code))
    else $error("active config moved without restart");
  AST_RATE_LEGAL: assert property (config_valid |-> bit_rate_code <= RATE_500K)
    else $error("rate code out of range");
  AST_SW_ADDR: assert property ($rose(config_valid) && address_tens_switch <= DIGIT_MAX &&
    address_units_switch <= DIGIT_MAX && sw_sum <= 8'(ADDR_MAX) &&
    $past(address_tens_switch, 4) == address_tens_switch &&
    $past(address_units_switch, 4) == address_units_switch |-> node_address == sw_sum[5:0])
    else $error("switch address not taken");
  AST_SW_RATE: assert property ($rose(config_valid) && rate_switch <= RATE_SW_MAX &&
    $past(rate_switch, 4) == rate_switch |-> bit_rate_code == rate_switch[1:0])
    else $error("switch rate not taken");
  AST_B_DROP: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write response repeated");
  AST_R_DROP: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read response repeated");
  AST_W_BLOCK: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write accepted while response pending");
  AST_R_BLOCK: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read accepted while data pending");
  AST_DEC_ZERO: assert property (s_axi_rvalid && s_axi_rresp == RESP_DECERR |-> s_axi_rdata == 32'h0)
    else $error("unmapped read data not zero");
  cover property ($rose(config_valid));
  cover property (s_axi_rvalid && s_axi_rresp == RESP_DECERR);
  cover property (s_axi_bvalid && s_axi_bready);
endmodule
bind fncs_top fncs_top_asserts fncs_top_asserts_i (.aclk, .aresetn, .address_tens_switch,
  .address_units_switch, .rate_switch, .s_axi_awready, .s_axi_wready, .s_axi_bvalid,
  .s_axi_bready, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
  .node_address, .bit_rate_code, .config_valid);

// file: bench/fncs_top_tb.sv
// self-checking bench for the node configuration selector
`timescale 1ns/10ps
module fncs_top_tb;
  import fncs_pkg::*;
  logic aclk = 1'b0; // 10 mhz clock
  logic aresetn = 1'b0; // reset held at start
  logic [3:0] address_tens_switch = 4'h1, address_units_switch = 4'h0, rate_switch = 4'h1;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, d;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, bit_rate_code, rs, r2;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, config_valid;
  logic [5:0] node_address;
  logic [15:0] tbl [4] = '{16'h0000, 16'h6322, 16'h3711, 16'h6430}; // tens,units,rate,code
  logic [5:0] ea [4] = '{6'h00, 6'h3f, 6'h25, 6'h3f}; // expected address per row
  int n_fail = 0, num_checks = 0, cyc = 0;
  always #50 aclk = ~aclk;
  fncs_top fncs_top_i (.aclk, .aresetn, .address_tens_switch, .address_units_switch,
    .rate_switch, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .node_address, .bit_rate_code, .config_valid);
  fncs_host_model fncs_host_model_i (.aclk, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
  // ----------------------------------------
  // compare, verdict and watchdog
  // ----------------------------------------
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic end_sim;
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // a hang anywhere ends the run as a failure
  always @(posedge aclk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      n_fail++;
      end_sim();
    end
  end
  // ----------------------------------------
  // access helpers
  // ----------------------------------------
  task automatic w(input logic [7:0] a, input logic [31:0] v, input logic [1:0] er);
    fncs_host_model_i.wr(a, v, rs);
    chk("bresp", rs, er);
  endtask
  task automatic r(input logic [7:0] a, input logic [31:0] ev, input logic [1:0] er);
    fncs_host_model_i.rd(a, d, rs);
    chk("rdata", d, ev);
    chk("rresp", rs, er);
  endtask
  task automatic outs(input logic [5:0] a, input logic [1:0] c);
    chk("node_address", node_address, a);
    chk("bit_rate_code", bit_rate_code, c);
  endtask
  // cold restart, then bounded wait for the reload to finish
  task automatic restart;
    w(OFS_CMD, {CMD_COLD, 28'h0}, RESP_OKAY);
    for (int i = 0; i < 20 && config_valid !== 1'b1; i++) @(posedge aclk);
    repeat (2) @(posedge aclk);
    chk("config_valid", config_valid, 1'b1);
  endtask
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial
  begin
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    for (int i = 0; i < 20 && config_valid !== 1'b1; i++) @(posedge aclk);
    repeat (2) @(posedge aclk);
    outs(6'h0a, RATE_250K);
    r(OFS_ACTIVE, 32'h1d0a, RESP_OKAY);
    r(OFS_SWITCH, 32'h0110, RESP_OKAY);
    // software values refused while switches rule
    w(OFS_CMD, {CMD_ADDR, 28'h5}, RESP_SLVERR);
    w(OFS_CMD, {CMD_RATE, 18'h0, KBPS_250}, RESP_SLVERR);
    w(OFS_OBJ, {OBJ_CLASS_LINK, OBJ_ATTR_ADDR, 16'h5}, RESP_SLVERR);
    w(OFS_OBJ, {OBJ_CLASS_LINK, OBJ_ATTR_RATE, 16'h1}, RESP_SLVERR);
    w(8'h20, 32'h1, RESP_DECERR);
    r(8'h20, 32'h0, RESP_DECERR);
    // switch table: a change is ignored until the next restart
    for (int i = 0; i < 4; i++)
    begin
      @(posedge aclk);
      {address_tens_switch, address_units_switch, rate_switch} <= tbl[i][15:4];
      repeat (6) @(posedge aclk);
      outs(i == 0 ? 6'h0a : ea[i-1], i == 0 ? RATE_250K : tbl[i-1][1:0]);
      restart();
      outs(ea[i], tbl[i][1:0]);
    end
    // stored values by command: only saved ones survive a restart
    w(OFS_CMD, {CMD_ADDR, 28'h5}, RESP_OKAY);
    w(OFS_CMD, {CMD_RATE, 18'h0, KBPS_500}, RESP_OKAY);
    w(OFS_CMD, {CMD_RATE, 18'h0, 10'h12c}, RESP_SLVERR);
    w(OFS_CMD, {CMD_ADDR, 28'h40}, RESP_SLVERR);
    r(OFS_PEND, 32'h0205, RESP_OKAY);
    restart();
    outs(6'h3f, RATE_125K);
    fncs_host_model_i.save_restart(rs, r2);
    for (int i = 0; i < 20 && config_valid !== 1'b1; i++) @(posedge aclk);
    repeat (2) @(posedge aclk);
    chk("save_resp", {rs, r2}, {RESP_OKAY, RESP_OKAY});
    outs(6'h05, RATE_500K);
    w(OFS_CMD, {CMD_RATE, 18'h0, KBPS_250}, RESP_OKAY);
    r(OFS_PEND, 32'h0105, RESP_OKAY);
    w(OFS_CMD, {CMD_RATE, 18'h0, KBPS_125}, RESP_OKAY);
    r(OFS_PEND, 32'h0005, RESP_OKAY);
    // stored values by network object, saved through the object too
    w(OFS_OBJ, {OBJ_CLASS_LINK, OBJ_ATTR_ADDR, 16'h2a}, RESP_OKAY);
    w(OFS_OBJ, {OBJ_CLASS_LINK, OBJ_ATTR_RATE, 16'h1}, RESP_OKAY);
    w(OFS_OBJ, {OBJ_CLASS_NVM, OBJ_ATTR_SAVE, 16'h0}, RESP_OKAY);
    r(OFS_SAVED, 32'h012a, RESP_OKAY);
    restart();
    outs(6'h2a, RATE_250K);
    r(OFS_ACTIVE, 32'h112a, RESP_OKAY);
    end_sim();
  end
endmodule
